// ### design/tsa_pkg.sv
// Command codes, reset values and field positions of the sensor register map.
// Assumes one byte-wide command port supplied by the serial front end.
`default_nettype none
package tsa_pkg;
  localparam logic [7:0] CMD_LTEMP   = 8'h00;
  localparam logic [7:0] CMD_RTEMP   = 8'h01;
  localparam logic [7:0] CMD_ST1     = 8'h02;
  localparam logic [7:0] CMD_CFG_R   = 8'h03;
  localparam logic [7:0] CMD_RATE_R  = 8'h04;
  localparam logic [7:0] CMD_LHI_R   = 8'h05;
  localparam logic [7:0] CMD_LLO_R   = 8'h06;
  localparam logic [7:0] CMD_RHI_R   = 8'h07;
  localparam logic [7:0] CMD_RLO_R   = 8'h08;
  localparam logic [7:0] CMD_CFG_W   = 8'h09;
  localparam logic [7:0] CMD_RATE_W  = 8'h0A;
  localparam logic [7:0] CMD_LHI_W   = 8'h0B;
  localparam logic [7:0] CMD_LLO_W   = 8'h0C;
  localparam logic [7:0] CMD_RHI_W   = 8'h0D;
  localparam logic [7:0] CMD_RLO_W   = 8'h0E;
  localparam logic [7:0] CMD_ONESHOT = 8'h0F;
  localparam logic [7:0] CMD_RFRAC   = 8'h10;
  localparam logic [7:0] CMD_LFRAC   = 8'h11;
  localparam logic [7:0] CMD_ST2     = 8'h12;
  localparam logic [7:0] CMD_ROTB    = 8'h16;
  localparam logic [7:0] CMD_LOTB    = 8'h17;
  localparam logic [7:0] CMD_ROTA    = 8'h19;
  localparam logic [7:0] CMD_LOTA    = 8'h20;
  localparam logic [7:0] CMD_OVERTEMP_RELEASE_MARGIN    = 8'h21;
  localparam logic [7:0] CMD_MAKER   = 8'hFE;
  // Reset values
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_CFG     = 8'h00;
  localparam logic [7:0] RST_RATE    = 8'h06;
  localparam logic [7:0] RST_HI      = 8'h46;
  localparam logic [7:0] RST_LO      = 8'hC9;
  localparam logic [7:0] RST_ROTB    = 8'h78;
  localparam logic [7:0] RST_LOTB    = 8'h5A;
  localparam logic [7:0] RST_ROTA    = 8'h5A;
  localparam logic [7:0] RST_LOTA    = 8'h46;
  localparam logic [7:0] RST_OVERTEMP_RELEASE_MARGIN    = 8'h0A;
  localparam logic [7:0] RST_ST1     = 8'h80;
  // Configuration fields
  localparam int CFG_MASK_ALL = 7;
  localparam int CFG_STBY     = 6;
  localparam int CFG_QUEUE    = 5;
  localparam int CFG_RSEL     = 3;
  localparam int CFG_ARA_DIS  = 2;
  localparam int CFG_MASK_R2  = 1;
  localparam int CFG_MASK_R1  = 0;
  // Status fields; status 2 uses the remote positions for channel 2
  localparam int ST_BUSY = 7;
  localparam int ST_LHI  = 6;
  localparam int ST_LLO  = 5;
  localparam int ST_RHI  = 4;
  localparam int ST_RLO  = 3;
  localparam int ST_RFLT = 2;
  // Data format
  localparam logic [7:0] EXT_RATE_MAX = 8'h05;
  localparam logic [7:0] T_SAT_HI     = 8'h7F;
  localparam logic [7:0] T_SAT_LO     = 8'h81;
  localparam logic [7:0] T_FAULT      = 8'h80;
  localparam logic [4:0] FRAC_PAD     = 5'h00;
  localparam logic [2:0] ARA_LAST     = 3'h7;
  typedef enum logic [0:0] {ARA_IDLE = 1'b0, ARA_SEND = 1'b1} tsa_ara_e;
endpackage
`default_nettype wire

// ### design/tsa_chan.sv
// One temperature channel: format, store and compare against alert limits.
// Assumes i_load pulses once at the end of each conversion.
`default_nettype none
module tsa_chan
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_load,
  input  wire logic [8:0] i_raw,
  input  wire logic [2:0] i_frac,
  input  wire logic       i_ext_ok,
  input  wire logic       i_fault,
  input  wire logic [7:0] i_hi_lim,
  input  wire logic [7:0] i_lo_lim,
  output logic      [7:0] o_temp,
  output logic      [7:0] o_frac,
  output logic            o_hi_hit,
  output logic            o_lo_hit
);
  import tsa_pkg::*;

  logic [7:0] temp_reg;
  logic [7:0] frac_reg;
  logic [7:0] temp_next;
  logic [7:0] frac_next;
  logic       over;
  logic       under;

  assign over      = ~i_raw[8] & (i_raw[7:0] > T_SAT_HI);
  assign under     = i_raw[8] & (i_raw[7:0] < T_SAT_LO);
  assign temp_next = i_fault ? T_FAULT :
                     over    ? T_SAT_HI :
                     under   ? T_SAT_LO : i_raw[7:0];
  assign frac_next = (i_ext_ok & ~i_fault & ~over & ~under)
                     ? {i_frac, FRAC_PAD} : RST_ZERO;
  // Faulted readings never count as limit crossings
  assign o_hi_hit  = ~i_fault & ($signed(temp_next) >= $signed(i_hi_lim));
  assign o_lo_hit  = ~i_fault & ($signed(temp_next) < $signed(i_lo_lim));
  assign o_temp    = temp_reg;
  assign o_frac    = frac_reg;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      temp_reg <= RST_ZERO;
      frac_reg <= RST_ZERO;
    end
    else if (i_load)
    begin
      temp_reg <= temp_next;
      frac_reg <= frac_next;
    end
  end

  property p_sat;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_load && !i_fault && over |=> temp_reg == T_SAT_HI;
  endproperty
  a_sat: assert property (p_sat) else $error("saturation missed");

  property p_fault;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_load && i_fault |=> temp_reg == T_FAULT && frac_reg == RST_ZERO;
  endproperty
  a_fault: assert property (p_fault) else $error("fault code missed");

  property p_frac;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_load && i_ext_ok && !i_fault && !over && !under
      |=> frac_reg[7:5] == $past(i_frac) && frac_reg[4:0] == FRAC_PAD;
  endproperty
  a_frac: assert property (p_frac) else $error("fraction misplaced");
endmodule // tsa_chan
`default_nettype wire

// ### design/tsa_regmap.sv
// Register map, alert latch and alert-response arbitration of the sensor.
// Assumes a serial front end that decodes commands into byte strobes,
// a converter that pulses i_conv_done with fresh raw readings, and
// i_bit_tick at the sample point of each alert-response data bit.
// Contract
// - Alert when temperature at or above high limit
// - Alert limits power up at +70 and -55
// - Saturate at 7Fh; diode fault reads 80h
// - Fraction in top three bits, 0.125 steps
// - Fraction valid only at rate 05h or below
// - Config bit 3 selects remote channel 2
// - 00h local, 01h remote temperature, reset zero
// - 10h remote, 11h local fraction, reset zero
// - 02h status one (80h), 12h status two
// - Config read at 03h, written at 09h
// - Rate read 04h, written 0Ah, reset 06h
// - Local limits read 05h/06h, written 0Bh/0Ch
// - Remote limits read 07h/08h, written 0Dh/0Eh
// - Overtemp limits at 16h, 17h, 19h, 20h
// - Shared hysteresis at 21h, reset 0Ah
// - Alert on high, low or open diode
// - Alert latched; cleared by status read or response
// - Reasserts next conversion if condition remains
// - At most one alert per conversion
// - Pending device answers alert response with address
// - Lower address wins; loser keeps alert asserted
// - Status read clears fault bit and alert
// - Open diode alerts, shorted diode does not
// - Config bit 7 masks all alerts
// - Config bits 1/0 mask remote 2/1 alerts
`default_nettype none
module tsa_regmap
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A  // Arbitrary value
)
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_cmd,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rd_valid,
  input  wire logic       i_conv_done,
  input  wire logic       i_busy,
  input  wire logic [8:0] i_loc_raw,
  input  wire logic [2:0] i_loc_frac,
  input  wire logic [8:0] i_r1_raw,
  input  wire logic [2:0] i_r1_frac,
  input  wire logic [8:0] i_r2_raw,
  input  wire logic [2:0] i_r2_frac,
  input  wire logic       i_r1_open,
  input  wire logic       i_r1_short,
  input  wire logic       i_r2_open,
  input  wire logic       i_r2_short,
  input  wire logic [6:0] i_own_addr,
  input  wire logic       i_ara_start,
  input  wire logic       i_bit_tick,
  input  wire logic       i_sda_in,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic            o_alert_out,
  output logic            o_alert_oe,
  output logic            o_one_shot,
  output logic            o_standby,
  output logic            o_queue_en,
  output logic            o_timeout_dis,
  output logic      [7:0] o_conv_rate
);
  import tsa_pkg::*;

  logic [7:0] cfg_reg;
  logic [7:0] rate_reg;
  logic [7:0] lhi_reg;
  logic [7:0] llo_reg;
  logic [7:0] rhi_reg [2];
  logic [7:0] rlo_reg [2];
  logic [7:0] rota_reg [2];
  logic [7:0] rotb_reg [2];
  logic [7:0] lota_reg;
  logic [7:0] lotb_reg;
  logic [7:0] overtemp_release_margin_reg;
  logic [7:0] st1_reg;
  logic [7:0] st2_reg;
  logic [7:0] st1_next;
  logic [7:0] st2_next;
  logic       alert_reg;
  logic       alert_next;
  logic [7:0] rdata_reg;
  logic       rd_valid_reg;
  logic       one_shot_reg;
  tsa_ara_e   ara_reg;
  tsa_ara_e   ara_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic       sda_oe_reg;
  logic       sda_oe_next;

  logic       rsel;
  logic       ext_ok;
  logic [7:0] loc_temp;
  logic [7:0] loc_frac;
  logic [7:0] r1_temp;
  logic [7:0] r1_frac;
  logic [7:0] r2_temp;
  logic [7:0] r2_frac;
  logic       loc_hi;
  logic       loc_lo;
  logic       r1_hi;
  logic       r1_lo;
  logic       r2_hi;
  logic       r2_lo;
  logic       rd_st1;
  logic       rd_st2;
  logic       alert_set;
  logic       alert_clr;
  logic       ara_go;
  logic       ara_lost;
  logic       ara_win;
  logic [7:0] rd_data;

  assign rsel   = cfg_reg[CFG_RSEL];
  assign ext_ok = rate_reg <= EXT_RATE_MAX;

  tsa_chan u_loc (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (i_conv_done),
    .i_raw     (i_loc_raw),
    .i_frac    (i_loc_frac),
    .i_ext_ok  (ext_ok),
    .i_fault   (1'b0),
    .i_hi_lim  (lhi_reg),
    .i_lo_lim  (llo_reg),
    .o_temp    (loc_temp),
    .o_frac    (loc_frac),
    .o_hi_hit  (loc_hi),
    .o_lo_hit  (loc_lo)
  );

  tsa_chan u_r1 (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (i_conv_done),
    .i_raw     (i_r1_raw),
    .i_frac    (i_r1_frac),
    .i_ext_ok  (ext_ok),
    .i_fault   (i_r1_open | i_r1_short),
    .i_hi_lim  (rhi_reg[0]),
    .i_lo_lim  (rlo_reg[0]),
    .o_temp    (r1_temp),
    .o_frac    (r1_frac),
    .o_hi_hit  (r1_hi),
    .o_lo_hit  (r1_lo)
  );

  tsa_chan u_r2 (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (i_conv_done),
    .i_raw     (i_r2_raw),
    .i_frac    (i_r2_frac),
    .i_ext_ok  (ext_ok),
    .i_fault   (i_r2_open | i_r2_short),
    .i_hi_lim  (rhi_reg[1]),
    .i_lo_lim  (rlo_reg[1]),
    .o_temp    (r2_temp),
    .o_frac    (r2_frac),
    .o_hi_hit  (r2_hi),
    .o_lo_hit  (r2_lo)
  );

  // Status: set by conversion wins over clear by read
  assign rd_st1 = i_rd_en && (i_cmd == CMD_ST1);
  assign rd_st2 = i_rd_en && (i_cmd == CMD_ST2);
  assign st1_next = {i_busy,
    (st1_reg[6:0] & {7{~rd_st1}}) | ({7{i_conv_done}} &
    {loc_hi, loc_lo, r1_hi, r1_lo, i_r1_open | i_r1_short, 2'b00})};
  assign st2_next = {1'b0,
    (st2_reg[6:0] & {7{~rd_st2}}) | ({7{i_conv_done}} &
    {2'b00, r2_hi, r2_lo, i_r2_open | i_r2_short, 2'b00})};

  // Alert evaluated only at conversion end; shorted diodes excluded
  assign alert_set = i_conv_done & ~cfg_reg[CFG_MASK_ALL] & (
    loc_hi | loc_lo |
    (~cfg_reg[CFG_MASK_R1] & (r1_hi | r1_lo | i_r1_open)) |
    (~cfg_reg[CFG_MASK_R2] & (r2_hi | r2_lo | i_r2_open)));
  assign alert_clr  = rd_st1 | rd_st2 | ara_win;
  assign alert_next = alert_set | (alert_reg & ~alert_clr);

  // Alert response: send own address MSB first, drop out on lost bit
  assign ara_go   = (ara_reg == ARA_IDLE) & i_ara_start & alert_reg
                    & ~cfg_reg[CFG_ARA_DIS];
  assign ara_lost = (ara_reg == ARA_SEND) & i_bit_tick
                    & shift_reg[7] & ~i_sda_in;
  assign ara_win  = (ara_reg == ARA_SEND) & i_bit_tick & ~ara_lost
                    & (cnt_reg == ARA_LAST);
  assign ara_next = ara_go ? ARA_SEND :
                    (ara_lost | ara_win) ? ARA_IDLE : ara_reg;
  assign shift_next = ara_go ? {i_own_addr, 1'b0} :
                      ((ara_reg == ARA_SEND) & i_bit_tick)
                      ? {shift_reg[6:0], 1'b0} : shift_reg;
  assign cnt_next = ara_go ? 3'h0 :
                    ((ara_reg == ARA_SEND) & i_bit_tick)
                    ? cnt_reg + 3'h1 : cnt_reg;
  assign sda_oe_next = ara_go ? ~i_own_addr[6] :
                       (ara_lost | ara_win) ? 1'b0 :
                       ((ara_reg == ARA_SEND) & i_bit_tick)
                       ? ~shift_reg[6] : sda_oe_reg;

  assign rd_data =
    (i_cmd == CMD_LTEMP)  ? loc_temp :
    (i_cmd == CMD_RTEMP)  ? (rsel ? r2_temp : r1_temp) :
    (i_cmd == CMD_ST1)    ? st1_reg :
    (i_cmd == CMD_CFG_R)  ? cfg_reg :
    (i_cmd == CMD_RATE_R) ? rate_reg :
    (i_cmd == CMD_LHI_R)  ? lhi_reg :
    (i_cmd == CMD_LLO_R)  ? llo_reg :
    (i_cmd == CMD_RHI_R)  ? rhi_reg[rsel] :
    (i_cmd == CMD_RLO_R)  ? rlo_reg[rsel] :
    (i_cmd == CMD_RFRAC)  ? (rsel ? r2_frac : r1_frac) :
    (i_cmd == CMD_LFRAC)  ? loc_frac :
    (i_cmd == CMD_ST2)    ? st2_reg :
    (i_cmd == CMD_ROTB)   ? rotb_reg[rsel] :
    (i_cmd == CMD_LOTB)   ? lotb_reg :
    (i_cmd == CMD_ROTA)   ? rota_reg[rsel] :
    (i_cmd == CMD_LOTA)   ? lota_reg :
    (i_cmd == CMD_OVERTEMP_RELEASE_MARGIN)   ? overtemp_release_margin_reg :
    (i_cmd == CMD_MAKER)  ? MAKER_CODE : RST_ZERO;

  assign o_rdata       = rdata_reg;
  assign o_rd_valid    = rd_valid_reg;
  assign o_sda_out     = 1'b0;
  assign o_sda_oe      = sda_oe_reg;
  assign o_alert_out   = 1'b0;
  assign o_alert_oe    = alert_reg;
  assign o_one_shot    = one_shot_reg;
  assign o_standby     = cfg_reg[CFG_STBY];
  assign o_queue_en    = cfg_reg[CFG_QUEUE];
  assign o_timeout_dis = cfg_reg[CFG_ARA_DIS];
  assign o_conv_rate   = rate_reg;

  // Writable bytes; read-only codes ignore writes
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cfg_reg     <= RST_CFG;
      rate_reg    <= RST_RATE;
      lhi_reg     <= RST_HI;
      llo_reg     <= RST_LO;
      rhi_reg[0]  <= RST_HI;
      rhi_reg[1]  <= RST_HI;
      rlo_reg[0]  <= RST_LO;
      rlo_reg[1]  <= RST_LO;
      rotb_reg[0] <= RST_ROTB;
      rotb_reg[1] <= RST_ROTB;
      rota_reg[0] <= RST_ROTA;
      rota_reg[1] <= RST_ROTA;
      lotb_reg    <= RST_LOTB;
      lota_reg    <= RST_LOTA;
      overtemp_release_margin_reg    <= RST_OVERTEMP_RELEASE_MARGIN;
    end
    else if (i_wr_en)
    begin
      unique case (i_cmd)
        CMD_CFG_W:  cfg_reg        <= i_wdata;
        CMD_RATE_W: rate_reg       <= i_wdata;
        CMD_LHI_W:  lhi_reg        <= i_wdata;
        CMD_LLO_W:  llo_reg        <= i_wdata;
        CMD_RHI_W:  rhi_reg[rsel]  <= i_wdata;
        CMD_RLO_W:  rlo_reg[rsel]  <= i_wdata;
        CMD_ROTB:   rotb_reg[rsel] <= i_wdata;
        CMD_LOTB:   lotb_reg       <= i_wdata;
        CMD_ROTA:   rota_reg[rsel] <= i_wdata;
        CMD_LOTA:   lota_reg       <= i_wdata;
        CMD_OVERTEMP_RELEASE_MARGIN:   overtemp_release_margin_reg       <= i_wdata;
        default:    cfg_reg        <= cfg_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st1_reg      <= RST_ST1;
      st2_reg      <= RST_ZERO;
      alert_reg    <= 1'b0;
      rdata_reg    <= RST_ZERO;
      rd_valid_reg <= 1'b0;
      one_shot_reg <= 1'b0;
      ara_reg      <= ARA_IDLE;
      shift_reg    <= RST_ZERO;
      cnt_reg      <= 3'h0;
      sda_oe_reg   <= 1'b0;
    end
    else
    begin
      st1_reg      <= st1_next;
      st2_reg      <= st2_next;
      alert_reg    <= alert_next;
      rdata_reg    <= i_rd_en ? rd_data : rdata_reg;
      rd_valid_reg <= i_rd_en;
      one_shot_reg <= i_wr_en && (i_cmd == CMD_ONESHOT);
      ara_reg      <= ara_next;
      shift_reg    <= shift_next;
      cnt_reg      <= cnt_next;
      sda_oe_reg   <= sda_oe_next;
    end
  end

  property p_hi_alert;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_conv_done && loc_hi && !cfg_reg[CFG_MASK_ALL] |=> o_alert_oe;
  endproperty
  a_hi_alert: assert property (p_hi_alert) else $error("high limit no alert");

  property p_rd_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
    (rd_st1 || rd_st2) && !i_conv_done |=> !o_alert_oe;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("status read kept alert");

  property p_once;
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_alert_oe) |-> $past(i_conv_done);
  endproperty
  a_once: assert property (p_once) else $error("alert outside conversion");

  property p_mask_all;
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_alert_oe) |-> !$past(cfg_reg[CFG_MASK_ALL]);
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked alert raised");

  property p_mask_ch;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_conv_done && !alert_reg && cfg_reg[CFG_MASK_R1] && cfg_reg[CFG_MASK_R2]
      && !loc_hi && !loc_lo |=> !o_alert_oe;
  endproperty
  a_mask_ch: assert property (p_mask_ch) else $error("channel mask ignored");

  property p_short;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_conv_done && !alert_reg && i_r1_short && !i_r1_open && !loc_hi && !loc_lo
      && !i_r2_open && !i_r2_short && !r2_hi && !r2_lo |=> !o_alert_oe;
  endproperty
  a_short: assert property (p_short) else $error("short diode alerted");

  property p_cfg_rd;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_rd_en && i_cmd == CMD_CFG_R |=> o_rd_valid && o_rdata == $past(cfg_reg);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");

  property p_rsel;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_rd_en && i_cmd == CMD_RTEMP && rsel |=> o_rdata == $past(r2_temp);
  endproperty
  a_rsel: assert property (p_rsel) else $error("remote select wrong");

  property p_lose;
    @(posedge i_clk) disable iff (!i_reset_n)
    ara_lost && alert_reg && !rd_st1 && !rd_st2
      |=> !o_sda_oe && o_alert_oe && ara_reg == ARA_IDLE;
  endproperty
  a_lose: assert property (p_lose) else $error("lost arbitration mishandled");

  property p_ext;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_conv_done && !ext_ok |=> loc_frac == RST_ZERO;
  endproperty
  a_ext: assert property (p_ext) else $error("fraction at fast rate");

  c_alert: cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(o_alert_oe));
  c_win:   cover property (@(posedge i_clk) disable iff (!i_reset_n) ara_win);
  c_lost:  cover property (@(posedge i_clk) disable iff (!i_reset_n) ara_lost);
  c_clear: cover property (@(posedge i_clk) disable iff (!i_reset_n)
                           alert_reg && rd_st1);
endmodule // tsa_regmap
`default_nettype wire

// ### verif/tsa_host.sv
// Host master model for the alert response, with an optional rival device.
// Assumes the bench calls ara and the shared data line has a pull-up.
`default_nettype none
module tsa_host
(
  input  wire logic i_clk,
  input  wire logic i_sda_oe,
  output logic      o_ara_start,
  output logic      o_bit_tick,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rv_oe = 1'b0;
  assign o_sda = ~(i_sda_oe | rv_oe);
  initial o_ara_start = 1'b0;
  initial o_bit_tick = 1'b0;
  // Receive byte at the response address; rival drops out on a lost bit
  // Got collects the resolved line at each bit sample point
  task automatic ara(input logic en, input logic [7:0] b,
                     output logic [7:0] got);
    @(negedge i_clk) o_ara_start = 1'b1;
    @(negedge i_clk) o_ara_start = 1'b0;
    rv_oe = en & ~b[7];
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge i_clk) o_bit_tick = 1'b1;
      got = {got[6:0], o_sda};
      en = en & (o_sda === b[7]);
      @(negedge i_clk) o_bit_tick = 1'b0;
      b = b << 1;
      rv_oe = en & (i > 0) & ~b[7];
    end
  endtask
endmodule  // tsa_host
`default_nettype wire

// ### verif/tb_top.sv
// Bench for the sensor register map: reset values, access, alerts, response.
// Assumes tsa_host answers the alert response on the shared data line.
`default_nettype none
module tb_top;
  import tsa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, rst_n = 0, we = 0, re = 0, cd = 0, op = 0, sh = 0;
  logic [7:0] cmd = 0, wd = 0, rdd, x;
  logic [8:0] raw = 0;
  logic [2:0] fr = 0;
  logic       rv, soe, al, st, tk, sd, sdo, alo, os, sb, qe, td;
  logic [7:0] cr;
  logic [39:0] lm = 40'h20F0_20F0_05;
  int         n_mismatch = 0, n_compared = 0, t;
  logic [15:0] rc [19] = '{16'h0000, 16'h0100, 16'h0280, 16'h0300, 16'h0406, 16'h0546,
    16'h06C9, 16'h0746, 16'h08C9, 16'h1000, 16'h1100, 16'h1200, 16'h1678, 16'h175A,
    16'h195A, 16'h2046, 16'h210A, 16'hFE3C, 16'h3000};
  logic [15:0] wp [10] = '{16'h0B05, 16'h0C06, 16'h0D07, 16'h0E08, 16'h0A04, 16'h1616,
    16'h1717, 16'h1919, 16'h2020, 16'h2121};
  tsa_regmap #(.MAKER_CODE(8'h3C)) uut (.i_clk(clk), .i_reset_n(rst_n), .i_wr_en(we),
    .i_rd_en(re), .i_cmd(cmd), .i_wdata(wd), .o_rdata(rdd), .o_rd_valid(rv),
    .i_conv_done(cd), .i_busy(1'b1), .i_loc_raw(raw), .i_loc_frac(fr), .i_r1_raw(raw),
    .i_r1_frac(fr), .i_r2_raw(raw), .i_r2_frac(fr), .i_r1_open(op), .i_r1_short(sh),
    .i_r2_open(1'b0), .i_r2_short(1'b0), .i_own_addr(7'h2A), .i_ara_start(st),
    .i_bit_tick(tk), .i_sda_in(sd), .o_sda_out(sdo), .o_sda_oe(soe), .o_alert_out(alo),
    .o_alert_oe(al), .o_one_shot(os), .o_standby(sb), .o_queue_en(qe), .o_timeout_dis(td),
    .o_conv_rate(cr));
  tsa_host host (.i_clk(clk), .i_sda_oe(soe), .o_ara_start(st), .o_bit_tick(tk), .o_sda(sd));
  initial forever #12.5 clk = ~clk;
  function automatic logic [7:0] hit(int v);
    return {7'h00, v >= 32 || v < -16};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    @(negedge clk) {re, cmd} = {1'b1, c};
    @(negedge clk) re = 1'b0;
    chk(rv ? rdd : 8'hxx, e);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(negedge clk) {we, cmd, wd} = {1'b1, c, d};
    @(negedge clk) we = 1'b0;
  endtask
  task automatic cv(input logic [8:0] r, input logic [2:0] f, input logic o, input logic s);
    @(negedge clk) {cd, raw, fr, op, sh} = {1'b1, r, f, o, s};
    @(negedge clk) cd = 1'b0;
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    x = 8'($urandom(32'h5dea));
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    foreach (rc[i]) rd(rc[i][15:8], rc[i][7:0]);
    wr(CMD_MAKER, 8'h00);
    rd(CMD_MAKER, 8'h3C);
    foreach (wp[i])
    begin
      x = 8'($urandom);
      wr(wp[i][15:8], x);
      rd(wp[i][7:0], x);
    end
    wr(8'h0D, 8'h33);
    wr(8'h09, 8'h08);
    rd(8'h03, 8'h08);
    rd(8'h07, 8'h46);
    wr(8'h0D, 8'h11);
    wr(8'h09, 8'h02);
    rd(8'h07, 8'h33);
    foreach (wp[i]) wr(wp[i][15:8], lm[39 - 8 * (i % 5) -: 8]);
    repeat (12)
    begin
      t = int'($urandom_range(100)) - 40;
      cv(9'(t), 3'($urandom), 1'b0, 1'b0);
      chk({7'h00, al}, hit(t));
      rd(8'h00, 8'(t));
      rd(8'h11, {fr, 5'h00});
      rd(8'h02, {1'b1, t >= 32, t < -16, t >= 32, t < -16, 3'h0});
      chk({7'h00, al}, 8'h00);
      cv(9'(t), fr, 1'b0, 1'b0);
      chk({7'h00, al}, hit(t));
      rd(8'h12, {3'h0, t >= 17, 4'h0});
      chk({7'h00, al}, 8'h00);
      rd(8'h02, {1'b1, t >= 32, t < -16, t >= 32, t < -16, 3'h0});
    end
    wr(8'h0A, 8'h06);
    cv(9'h080, 3'h5, 1'b0, 1'b0);
    rd(8'h00, 8'h7F);
    rd(8'h11, 8'h00);
    rd(8'h02, 8'hD0);
    cv(9'h010, 3'h0, 1'b1, 1'b0);
    chk({7'h00, al}, 8'h01);
    rd(8'h01, 8'h80);
    rd(8'h02, 8'h84);
    chk({7'h00, al}, 8'h00);
    cv(9'h010, 3'h0, 1'b0, 1'b1);
    chk({7'h00, al}, 8'h00);
    rd(8'h02, 8'h84);
    wr(8'h09, 8'h83);
    cv(9'h050, 3'h0, 1'b0, 1'b0);
    chk({7'h00, al}, 8'h00);
    rd(8'h02, 8'hD0);
    wr(8'h09, 8'h03);
    cv(9'h010, 3'h0, 1'b1, 1'b0);
    chk({7'h00, al}, 8'h00);
    rd(8'h02, 8'h84);
    wr(8'h09, 8'h02);
    cv(9'h050, 3'h0, 1'b0, 1'b0);
    host.ara(1'b0, 8'h00, x);
    chk({7'h00, al}, 8'h00);
    chk(x, 8'h54);
    cv(9'h050, 3'h0, 1'b0, 1'b0);
    host.ara(1'b1, {7'h10, 1'b0}, x);
    chk({6'h00, al, soe}, 8'h02);
    chk(x, 8'h20);
    host.ara(1'b1, {7'h50, 1'b0}, x);
    chk({7'h00, al}, 8'h00);
    chk(x, 8'h54);
    // Standby, queue and response-disable bits set; response must be ignored
    wr(8'h09, 8'h64);
    cv(9'h050, 3'h0, 1'b0, 1'b0);
    wr(8'h0F, 8'h00);
    chk({2'b00, sdo, alo, os, sb, qe, td}, 8'h0F);
    chk(cr, 8'h06);
    host.ara(1'b0, 8'h00, x);
    chk({x[7:1], al}, 8'hFF);
    results;
  end
  initial
  begin
    #300us;
    n_mismatch++;
    results;
  end
endmodule  // tb_top
`default_nettype wire
